/* File: frame_timing_model.sv */
/* sensor timing model: all-rows, row tick and pre-readout pulses.
   assumes go_in pulses from the bench on mclk_in. */
`timescale 1ns/1ps
`default_nettype none
module frame_timing_model (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic go_in,
  output logic all_out,
  output logic tick_out,
  output logic last_out
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  assign cnt_d = go_in ? 3'h1 : (cnt_q == 3'h0 || cnt_q == 3'h6) ? 3'h0 : cnt_q + 3'h1;
  always_ff @(posedge mclk_in)
    cnt_q <= rstn_in ? cnt_d : 3'h0;
  assign all_out = cnt_q == 3'h1;
  assign tick_out = cnt_q == 3'h2;
  assign last_out = cnt_q == 3'h6;
endmodule
`default_nettype wire

/* File: frame_trigger_strobe_window.sv */
/*
  frame trigger, flash strobe and window-of-interest register block:
  control, capture-mode and window registers, a two-flop synchroniser
  on the trigger pin and the automatic strobe sequencer.
  window values are stored as written, with no range check.
  assumes an 8-bit register port on mclk_in and row timing events
  (all rows integrating, row tick, one row before readout) from the
  sensor timing logic on the same clock; the trigger pin is asynchronous.
  the row-time events must be single-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "trigger_strobe_defs.svh"

module frame_trigger_strobe_window
  import trigger_strobe_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic trigger_pin_in,
  input wire logic all_rows_integrating_in,
  input wire logic row_tick_in,
  input wire logic row_before_readout_in,
  output logic frame_trigger_out,
  output logic strobe_out,
  output logic single_frame_rolling_out,
  output window_of_interest_t window_of_interest_out,
  output logic [10:0] window_rows_out
);

  control_t ctrl_q, ctrl_d;
  logic single_frame_rolling_q, single_frame_rolling_d;
  window_of_interest_t woi_q, woi_d;
  logic request_q, request_d;
  logic trig_meta_q, trig_meta_d;
  logic trig_sync_q, trig_sync_d;
  logic frame_trigger_q, frame_trigger_d;
  logic strobe_q, strobe_d;
  strobe_state_t state_q, state_d;
  logic [7:0] rdata_q, rdata_d;
  logic [10:0] rows_q, rows_d;

  function automatic logic [7:0] high_byte(input logic [10:0] v);
    high_byte = {5'h00, v[10:8]};
  endfunction

  // row count of the window
  function automatic logic [10:0] window_rows(input logic [10:0] size);
    window_rows = 11'(size + 11'h001);
  endfunction

  // register writes; no range checking of window values
  always_comb
  begin
    ctrl_d = ctrl_q;
    single_frame_rolling_d = single_frame_rolling_q;
    woi_d = woi_q;
    request_d = 1'b0;
    if (reg_write_in)
    begin
      unique case (reg_addr_in)
        `OFS_CAPTURE_MODE:
          single_frame_rolling_d = reg_wdata_in[`BIT_SINGLE_FRAME_ROLLING];
        `OFS_TRIGGER_STROBE_CONTROL:
        begin
          request_d = reg_wdata_in[`BIT_TRIGGER_REQUEST];
          ctrl_d.trigger_always = reg_wdata_in[`BIT_TRIGGER_ALWAYS];
          ctrl_d.external_trigger_enable = reg_wdata_in[`BIT_EXTERNAL_TRIGGER_ENABLE];
          ctrl_d.strobe_auto = reg_wdata_in[`BIT_STROBE_AUTO];
          ctrl_d.strobe_width = reg_wdata_in[`BIT_STROBE_WIDTH];
          ctrl_d.strobe_force = reg_wdata_in[`BIT_STROBE_FORCE];
        end
        `OFS_WINDOW_ROW_START_HIGH: woi_d.row_start[10:8] = reg_wdata_in[2:0];
        `OFS_WINDOW_ROW_START_LOW: woi_d.row_start[7:0] = reg_wdata_in;
        `OFS_WINDOW_ROW_SIZE_HIGH: woi_d.row_size[10:8] = reg_wdata_in[2:0];
        `OFS_WINDOW_ROW_SIZE_LOW: woi_d.row_size[7:0] = reg_wdata_in;
        `OFS_WINDOW_COL_START_HIGH: woi_d.col_start[10:8] = reg_wdata_in[2:0];
        `OFS_WINDOW_COL_START_LOW: woi_d.col_start[7:0] = reg_wdata_in;
        `OFS_WINDOW_COL_SIZE_HIGH: woi_d.col_size[10:8] = reg_wdata_in[2:0];
        `OFS_WINDOW_COL_SIZE_LOW: woi_d.col_size[7:0] = reg_wdata_in;
        default: ;
      endcase
    end
    rows_d = window_rows(woi_d.row_size);
  end

  // read mux; request bit always reads zero
  always_comb
  begin
    unique case (reg_addr_in)
      `OFS_CAPTURE_MODE: rdata_d = {1'b0, single_frame_rolling_q, 6'h00};
      `OFS_TRIGGER_STROBE_CONTROL: rdata_d = {2'h0, ctrl_q, 1'b0};
      `OFS_WINDOW_ROW_START_HIGH: rdata_d = high_byte(woi_q.row_start);
      `OFS_WINDOW_ROW_START_LOW: rdata_d = woi_q.row_start[7:0];
      `OFS_WINDOW_ROW_SIZE_HIGH: rdata_d = high_byte(woi_q.row_size);
      `OFS_WINDOW_ROW_SIZE_LOW: rdata_d = woi_q.row_size[7:0];
      `OFS_WINDOW_COL_START_HIGH: rdata_d = high_byte(woi_q.col_start);
      `OFS_WINDOW_COL_START_LOW: rdata_d = woi_q.col_start[7:0];
      `OFS_WINDOW_COL_SIZE_HIGH: rdata_d = high_byte(woi_q.col_size);
      `OFS_WINDOW_COL_SIZE_LOW: rdata_d = woi_q.col_size[7:0];
      default: rdata_d = 8'h00;
    endcase
  end

  // trigger pin synchroniser and frame trigger sources
  always_comb
  begin
    trig_meta_d = trigger_pin_in;
    trig_sync_d = trig_meta_q;
    frame_trigger_d = request_q
      | ctrl_q.trigger_always
      | (ctrl_q.external_trigger_enable & trig_sync_q);
  end

  // automatic strobe sequencer
  always_comb
  begin
    state_d = state_q;
    if (!(ctrl_q.strobe_auto && single_frame_rolling_q))
      state_d = ST_IDLE;
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (all_rows_integrating_in)
            state_d = ctrl_q.strobe_width ? ST_WIDE : ST_ONE_ROW;
        ST_WIDE:
          if (row_before_readout_in)
            state_d = ST_IDLE;
        ST_ONE_ROW:
          if (row_tick_in)
            state_d = ST_IDLE;
        default: state_d = ST_IDLE;
      endcase
    end
    // strobe output: force wins over automatic
    if (ctrl_q.strobe_force)
      strobe_d = 1'b1;
    else
      strobe_d = (state_d != ST_IDLE);
  end

  // register file
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      ctrl_q <= control_t'(5'(`RST_CONTROL >> 1));
      single_frame_rolling_q <= 1'(`RST_CAPTURE_MODE >> `BIT_SINGLE_FRAME_ROLLING);
      woi_q <= {`RST_ROW_START, `RST_COL_START, `RST_ROW_SIZE, `RST_COL_SIZE};
      rows_q <= window_rows(`RST_ROW_SIZE);
      request_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      single_frame_rolling_q <= single_frame_rolling_d;
      woi_q <= woi_d;
      rows_q <= rows_d;
      request_q <= request_d;
    end
  end

  // pin synchroniser and frame trigger
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
      frame_trigger_q <= 1'b0;
    end
    else
    begin
      trig_meta_q <= trig_meta_d;
      trig_sync_q <= trig_sync_d;
      frame_trigger_q <= frame_trigger_d;
    end
  end

  // strobe sequencer and strobe flop
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      state_q <= ST_IDLE;
      strobe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      strobe_q <= strobe_d;
    end
  end

  // registered read data
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flops
  assign frame_trigger_out = frame_trigger_q;
  assign strobe_out = strobe_q;
  assign single_frame_rolling_out = single_frame_rolling_q;
  assign window_of_interest_out = woi_q;
  assign window_rows_out = rows_q;
  assign reg_rdata_out = rdata_q;

endmodule
`default_nettype wire

/* File: frame_trigger_strobe_window_tb_top.sv */
/* bench for the trigger, strobe and window block.
   assumes the block, its checker and the timing model. */
`timescale 1ns/1ps
`default_nettype none
module frame_trigger_strobe_window_tb_top
  import trigger_strobe_pkg::*;
;
  logic mclk_in = 1'b0, rstn_in = 1'b0, reg_write_in = 1'b0, trigger_pin_in = 1'b0, go = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic all_rows_integrating_in, row_tick_in, row_before_readout_in;
  logic frame_trigger_out, strobe_out, single_frame_rolling_out;
  window_of_interest_t window_of_interest_out;
  logic [10:0] window_rows_out;
  int failures = 0, tests_run = 0, c;
  always #4 mclk_in = ~mclk_in;
  frame_timing_model i_frame_timing_model (.mclk_in, .rstn_in, .go_in(go),
    .all_out(all_rows_integrating_in), .tick_out(row_tick_in), .last_out(row_before_readout_in));
  frame_trigger_strobe_window i_frame_trigger_strobe_window (.*);
  task chk(input string n, input logic [15:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task wrt(input logic [7:0] a, d);
    @(posedge mclk_in);
    reg_write_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_write_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge mclk_in);
    reg_addr_in <= a;
    repeat (2) @(negedge mclk_in);
    chk("rdata", reg_rdata_out, e);
  endtask
  task cnt(input bit s, input int n);
    c = 0;
    repeat (n) @(negedge mclk_in) c += ((s ? strobe_out : frame_trigger_out) === 1'b1);
  endtask
  task frame(input logic [7:0] d, e);
    wrt(8'h42, d);
    @(posedge mclk_in) go <= 1'b1;
    @(posedge mclk_in) go <= 1'b0;
    cnt(1, 12);
    chk("strobe", c, e);
  endtask
  task t_trigger;
    rd(8'h46, 8'h10);
    chk("rows", window_rows_out, 16'h0400);
    rd(8'h50, 8'h00);
    wrt(8'h42, 8'h01);
    cnt(0, 8);
    chk("pulse", c, 16'h1);
    wrt(8'h42, 8'h03);
    cnt(0, 8);
    chk("always", c, 16'h7);
    rd(8'h42, 8'h02);
    wrt(8'h42, 8'h04);
    trigger_pin_in <= 1'b1;
    cnt(0, 4);
    cnt(0, 4);
    chk("ext on", c, 16'h4);
    @(posedge mclk_in) trigger_pin_in <= 1'b0;
    cnt(0, 4);
    cnt(0, 4);
    chk("ext off", c, 16'h0);
    $display("trigger test done");
  endtask
  task t_strobe;
    wrt(8'h40, 8'h40);
    rd(8'h40, 8'h40);
    chk("capture", single_frame_rolling_out, 16'h1);
    frame(8'h08, 16'h1);
    frame(8'h18, 16'h5);
    frame(8'h28, 16'hc);
    wrt(8'h42, 8'h00);
    cnt(1, 8);
    chk("release", c, 16'h1);
    wrt(8'h40, 8'h00);
    frame(8'h08, 16'h0);
    $display("strobe test done");
  endtask
  task t_window;
    wrt(8'h45, 8'hff);
    wrt(8'h46, 8'hff);
    wrt(8'h49, 8'h05);
    wrt(8'h4a, 8'h0f);
    wrt(8'h47, 8'h00);
    wrt(8'h4b, 8'h02);
    wrt(8'h4c, 8'h10);
    repeat (2) @(negedge mclk_in);
    chk("col size", window_of_interest_out.col_size, 16'h0210);
    chk("row start", window_of_interest_out.row_start, 16'h07ff);
    chk("col start", window_of_interest_out.col_start, 16'h050f);
    chk("rows", window_rows_out, 16'h0100);
    rd(8'h45, 8'h07);
    $display("window test done");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    t_trigger();
    t_strobe();
    t_window();
    end_sim();
  end
endmodule
`default_nettype wire

/* File: fts_chk.sv */
/* assertions for the trigger, strobe and window block.
   assumes bind onto the block's top module; one clock. */
`timescale 1ns/1ps
`default_nettype none
module fts_chk
  import trigger_strobe_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic all_rows_integrating_in,
  input wire logic row_tick_in,
  input wire logic row_before_readout_in,
  input wire logic frame_trigger_out,
  input wire logic strobe_out,
  input wire logic single_frame_rolling_out,
  input wire window_of_interest_t window_of_interest_out
);
  logic [7:0] ctl_q;
  logic w42;
  assign w42 = reg_write_in && reg_addr_in == 8'h42;
  always_ff @(posedge mclk_in)
    ctl_q <= !rstn_in ? 8'h00 : w42 ? reg_wdata_in : ctl_q;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);
  pulse_trig_a: assert property (w42 && reg_wdata_in[2:0] == 3'b001 ##1 !reg_write_in
    |=> frame_trigger_out ##1 !frame_trigger_out) else $error("trigger pulse wrong");
  held_trig_a: assert property (w42 && reg_wdata_in[1] |-> ##2 frame_trigger_out)
    else $error("trigger not held");
  force_strobe_a: assert property (w42 && reg_wdata_in[5] |-> ##2 strobe_out)
    else $error("strobe not forced");
  auto_rise_a: assert property (all_rows_integrating_in && ctl_q[3]
    && single_frame_rolling_out |=> strobe_out) else $error("strobe did not rise");
  no_auto_a: assert property (all_rows_integrating_in && !single_frame_rolling_out
    && !ctl_q[5] |=> !strobe_out) else $error("strobe in continuous mode");
  one_row_a: assert property (strobe_out && row_tick_in && !ctl_q[4] && !ctl_q[5]
    && !all_rows_integrating_in |=> !strobe_out) else $error("strobe over one row");
  long_end_a: assert property (strobe_out && row_before_readout_in && ctl_q[4]
    && !ctl_q[5] && !all_rows_integrating_in |=> !strobe_out) else $error("strobe too long");
  row_hi_a: assert property (reg_write_in && reg_addr_in == 8'h45 |=>
    window_of_interest_out.row_start[10:8] == $past(reg_wdata_in[2:0])) else $error("row start");
  cover property (strobe_out && ctl_q[4]);
  cover property (frame_trigger_out && ctl_q[2]);
  cover property (strobe_out && ctl_q[5]);
endmodule
bind frame_trigger_strobe_window fts_chk i_fts_chk (.*);
`default_nettype wire

/* File: trigger_strobe_defs.svh */
/*
  register offsets, field positions and reset values for the
  frame trigger, flash strobe and window-of-interest block.
  assumes an 8-bit register port addressed by the documented offsets.
*/
// Overview of operation
// - request bit gives one-cycle trigger pulse
// - always bit holds trigger high continuously
// - external enable lets trigger pin drive trigger
// - auto enable makes device generate strobe
// - auto strobe only in single-frame rolling mode
// - auto strobe rises when all rows integrate
// - width one: high until row before readout
// - width zero: high for one row period
// - force bit holds strobe high until cleared
// - force bit overrides auto enable and width
// - row and column start give window corner
// - no check or limit on window settings
// - row start is high[2:0] joined with low
// - capture bit: zero continuous, one single-frame
// - window rows equal row size plus one
`ifndef TRIGGER_STROBE_DEFS_SVH
`define TRIGGER_STROBE_DEFS_SVH

`define OFS_CAPTURE_MODE 8'h40
`define OFS_TRIGGER_STROBE_CONTROL 8'h42
`define OFS_WINDOW_ROW_START_HIGH 8'h45
`define OFS_WINDOW_ROW_START_LOW 8'h46
`define OFS_WINDOW_ROW_SIZE_HIGH 8'h47
`define OFS_WINDOW_ROW_SIZE_LOW 8'h48
`define OFS_WINDOW_COL_START_HIGH 8'h49
`define OFS_WINDOW_COL_START_LOW 8'h4a
`define OFS_WINDOW_COL_SIZE_HIGH 8'h4b
`define OFS_WINDOW_COL_SIZE_LOW 8'h4c

`define BIT_TRIGGER_REQUEST 0
`define BIT_TRIGGER_ALWAYS 1
`define BIT_EXTERNAL_TRIGGER_ENABLE 2
`define BIT_STROBE_AUTO 3
`define BIT_STROBE_WIDTH 4
`define BIT_STROBE_FORCE 5
`define BIT_SINGLE_FRAME_ROLLING 6

`define RST_CONTROL 8'h00
`define RST_CAPTURE_MODE 8'h00
`define RST_ROW_START 11'h010
`define RST_ROW_SIZE 11'h3ff
`define RST_COL_START 11'h008
`define RST_COL_SIZE 11'h4ff

`endif

/* File: trigger_strobe_pkg.sv */
/*
  types for the frame trigger, flash strobe and window-of-interest block.
  assumes trigger_strobe_defs.svh for all register numbers.
*/
`default_nettype none
package trigger_strobe_pkg;

  typedef struct packed {
    logic strobe_force;
    logic strobe_width;
    logic strobe_auto;
    logic external_trigger_enable;
    logic trigger_always;
  } control_t;

  typedef struct packed {
    logic [10:0] row_start;
    logic [10:0] col_start;
    logic [10:0] row_size;
    logic [10:0] col_size;
  } window_of_interest_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WIDE = 3'b010,
    ST_ONE_ROW = 3'b100
  } strobe_state_t;

endpackage
`default_nettype wire
